// ===== design/dma_mux_params.svh
// Constants for the channel interrupt and request mapping block
`ifndef DMA_MUX_PARAMS_SVH
`define DMA_MUX_PARAMS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define NUM_CH        7
`define NUM_SRC       16
`define MAP_W         4
`define ADR_MIN_W     8

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_FLAG      8'h00
`define OFS_CLEAR     8'h04
`define OFS_CTRL0     8'h08
`define CTRL_STRIDE   8'h14
`define OFS_REMAP     8'hA0
`define OFS_SRC_EN    8'hA4
`define OFS_IRQ_STAT  8'hA8
`define OFS_IRQ_MASK  8'hAC

// ----------------------------------------------------------------------
// Field layouts and reset values
// ----------------------------------------------------------------------
`define CTRL_WMASK    32'h0000_703F
`define REMAP_WMASK   32'h0000_000F
`define WORD_ZERO     32'h0000_0000
`define SEL_WORD      4'hF
`define BIT_EN        0
`define BIT_FULL_IE   1
`define BIT_HALF_IE   2
`define BIT_ERR_IE    3
`define FLD_ANY       0
`define FLD_FULL      1
`define FLD_HALF      2
`define FLD_ERR       3
`define FLD_W         4

// ----------------------------------------------------------------------
// Source routing tables, one nibble per source, source 0 lowest
// ----------------------------------------------------------------------
`define SRC_DEF_CH    64'h2436_5432_1002_2210
`define SRC_ALT_CH    64'h2436_5432_1113_3431
`define SRC_RMP_BIT   64'h0000_0000_0332_2110

`endif

// ===== design/dma_mux_pkg.sv
// Shared types for the channel interrupt and request mapping block
`default_nettype none
`include "dma_mux_params.svh"
package dma_mux_pkg;
    typedef logic [31:0]          word_t;
    typedef logic [`NUM_CH-1:0]   chan_vec_t;
    typedef logic [`NUM_SRC-1:0]  src_vec_t;
endpackage : dma_mux_pkg
`default_nettype wire

// ===== design/evt_if.sv
// Event set, clear and flag signals between control and flag store
`timescale 1ns/1ps
`default_nettype none
`include "dma_mux_params.svh"
interface evt_if;
    logic [`NUM_CH-1:0] set_full;
    logic [`NUM_CH-1:0] set_half;
    logic [`NUM_CH-1:0] set_err;
    logic [`NUM_CH-1:0] clr_full;
    logic [`NUM_CH-1:0] clr_half;
    logic [`NUM_CH-1:0] clr_err;
    logic [`NUM_CH-1:0] full;
    logic [`NUM_CH-1:0] half;
    logic [`NUM_CH-1:0] err;

    modport ctrl (
        output set_full, set_half, set_err,
        output clr_full, clr_half, clr_err,
        input  full, half, err
    );
    modport store (
        input  set_full, set_half, set_err,
        input  clr_full, clr_half, clr_err,
        output full, half, err
    );
endinterface : evt_if
`default_nettype wire

// ===== design/event_flag_store.sv
// Sticky per-channel event flags
`timescale 1ns/1ps
`default_nettype none
`include "dma_mux_params.svh"
module event_flag_store
    import dma_mux_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Events and clears
    evt_if.store      port
);
    chan_vec_t full_r, full_nxt;
    chan_vec_t half_r, half_nxt;
    chan_vec_t err_r,  err_nxt;

    // Set beats clear so a same-cycle event is not lost
    always_comb begin
        full_nxt = (full_r & ~port.clr_full) | port.set_full;
        half_nxt = (half_r & ~port.clr_half) | port.set_half;
        err_nxt  = (err_r  & ~port.clr_err)  | port.set_err;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            full_r <= '0;
            half_r <= '0;
            err_r  <= '0;
        end else begin
            full_r <= full_nxt;
            half_r <= half_nxt;
            err_r  <= err_nxt;
        end
    end

    assign port.full = full_r;
    assign port.half = half_r;
    assign port.err  = err_r;
endmodule : event_flag_store
`default_nettype wire

// ===== design/request_router.sv
// Maps peripheral request lines onto channels, honouring remap bits
`timescale 1ns/1ps
`default_nettype none
`include "dma_mux_params.svh"
module request_router
    import dma_mux_pkg::*;
#(
    parameter int NUM_SRC = `NUM_SRC
) (
    // Peripheral side
    input  wire logic [NUM_SRC-1:0] src_req,
    input  wire logic [NUM_SRC-1:0] src_en,
    // Remap settings
    input  wire logic [3:0]         remap,
    // Channel side
    output logic [`NUM_CH-1:0]      chan_req
);
    localparam logic [63:0] DEF_TBL = `SRC_DEF_CH;
    localparam logic [63:0] ALT_TBL = `SRC_ALT_CH;
    localparam logic [63:0] RMP_TBL = `SRC_RMP_BIT;

    // Routing tables are fixed for exactly this source count
    if (NUM_SRC != `NUM_SRC) begin : g_bad_src
        $error("request_router: NUM_SRC must match routing table");
    end

    function automatic logic [2:0] target(input int s,
                                          input logic [3:0] rm);
        logic [1:0] rb;
        rb = RMP_TBL[s*`MAP_W +: 2];
        if (rm[rb]) begin
            target = ALT_TBL[s*`MAP_W +: 3];
        end else begin
            target = DEF_TBL[s*`MAP_W +: 3];
        end
    endfunction : target

    // Only enabled sources feed the per-channel OR
    always_comb begin
        chan_req = '0;
        for (int s = 0; s < NUM_SRC; s++) begin
            if (src_req[s] && src_en[s]) begin
                chan_req[target(s, remap)] = 1'b1;
            end
        end
    end
endmodule : request_router
`default_nettype wire

// ===== design/dma_channel_irq_request_mux.sv
// Channel control, event flags, interrupts and request mapping top
`timescale 1ns/1ps
`default_nettype none
`include "dma_mux_params.svh"

module dma_channel_irq_request_mux
    import dma_mux_pkg::*;
#(
    parameter int ADR_W = `ADR_MIN_W
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // Wishbone classic slave
    input  wire logic             wb_cyc,
    input  wire logic             wb_stb,
    input  wire logic             wb_we,
    input  wire logic [ADR_W-1:0] wb_adr,
    input  wire logic [3:0]       wb_sel,
    input  wire logic [31:0]      wb_dat_w,
    output logic      [31:0]      wb_dat_r,
    output logic                  wb_ack,
    // Transfer events from the channel engine
    input  wire logic [6:0]       evt_full_done,
    input  wire logic [6:0]       evt_half_done,
    input  wire logic [6:0]       evt_xfer_error,
    // Peripheral request lines
    input  wire logic [15:0]      src_req,
    // Channel side
    output logic      [6:0]       channel_enable,
    output logic      [6:0]       chan_req,
    output logic      [6:0]       chan_irq,
    // Summary interrupt
    output logic                  irq
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (ADR_W < `ADR_MIN_W) begin : g_bad_adr
        $error("dma_channel_irq_request_mux: ADR_W too small");
    end

    if (`NUM_CH * `FLD_W > $bits(word_t)) begin : g_bad_flags
        $error("dma_channel_irq_request_mux: flag word too narrow");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    word_t     ctrl_r [`NUM_CH];
    word_t     ctrl_nxt [`NUM_CH];
    logic [3:0] remap_r, remap_nxt;
    src_vec_t  src_en_r, src_en_nxt;
    chan_vec_t stat_r, stat_nxt;
    chan_vec_t mask_r, mask_nxt;
    chan_vec_t req_r, req_nxt;
    chan_vec_t cirq_r, cirq_nxt;
    logic      irq_r, irq_nxt;
    logic      ack_r, ack_nxt;
    word_t     rdata_r, rdata_nxt;

    chan_vec_t routed;
    chan_vec_t en_vec;
    word_t     flag_word;
    logic [7:0] adr;
    logic      req;
    logic      take;
    logic      done;
    logic      wr;
    logic      rd_stat;

    evt_if ev ();

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] ctrl_ofs(input int ch);
        ctrl_ofs = 8'(`OFS_CTRL0 + `CTRL_STRIDE * ch);
    endfunction : ctrl_ofs

    function automatic logic is_ctrl(input logic [7:0] a,
                                     input int ch);
        is_ctrl = (a == ctrl_ofs(ch));
    endfunction : is_ctrl

    // Bit of one field of one channel in the flag and clear words
    function automatic int fbit(input int ch, input int fld);
        fbit = ch * `FLD_W + fld;
    endfunction : fbit

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    event_flag_store u_flags (
        .clk_sys (clk_sys),
        .rst     (rst),
        .port    (ev.store)
    );

    request_router #(
        .NUM_SRC (`NUM_SRC)
    ) u_router (
        .src_req  (src_req),
        .src_en   (src_en_r),
        .remap    (remap_r),
        .chan_req (routed)
    );

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Write lands on the edge the master sees ack, not earlier
    always_comb begin
        adr     = wb_adr[7:0];
        req     = wb_cyc && wb_stb;
        take    = req && !ack_r;
        done    = req && ack_r;
        wr      = done && wb_we && (wb_sel == `SEL_WORD);
        rd_stat = done && !wb_we && (adr == `OFS_IRQ_STAT);
    end

    // ------------------------------------------------------------------
    // Flag word and event hookup
    // ------------------------------------------------------------------
    always_comb begin
        flag_word = `WORD_ZERO;
        for (int c = 0; c < `NUM_CH; c++) begin
            flag_word[fbit(c, `FLD_FULL)] = ev.full[c];
            flag_word[fbit(c, `FLD_HALF)] = ev.half[c];
            flag_word[fbit(c, `FLD_ERR)]  = ev.err[c];
            flag_word[fbit(c, `FLD_ANY)]  =
                ev.full[c] | ev.half[c] | ev.err[c];
        end
    end

    always_comb begin
        ev.set_full = evt_full_done;
        ev.set_half = evt_half_done;
        ev.set_err  = evt_xfer_error;
        ev.clr_full = '0;
        ev.clr_half = '0;
        ev.clr_err  = '0;
        if (wr && adr == `OFS_CLEAR) begin
            for (int c = 0; c < `NUM_CH; c++) begin
                // Any-event clear wipes all three; zero bits do nothing
                ev.clr_full[c] = wb_dat_w[fbit(c, `FLD_FULL)] |
                                 wb_dat_w[fbit(c, `FLD_ANY)];
                ev.clr_half[c] = wb_dat_w[fbit(c, `FLD_HALF)] |
                                 wb_dat_w[fbit(c, `FLD_ANY)];
                ev.clr_err[c]  = wb_dat_w[fbit(c, `FLD_ERR)] |
                                 wb_dat_w[fbit(c, `FLD_ANY)];
            end
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_comb begin
        remap_nxt  = remap_r;
        src_en_nxt = src_en_r;
        mask_nxt   = mask_r;
        for (int c = 0; c < `NUM_CH; c++) begin
            ctrl_nxt[c] = ctrl_r[c];
            // Settings may be written in any order; enable is one bit
            if (wr && is_ctrl(adr, c)) begin
                ctrl_nxt[c] = wb_dat_w & `CTRL_WMASK;
            end
        end
        if (wr && adr == `OFS_REMAP) begin
            remap_nxt = 4'(wb_dat_w & `REMAP_WMASK);
        end
        if (wr && adr == `OFS_SRC_EN) begin
            src_en_nxt = wb_dat_w[`NUM_SRC-1:0];
        end
        if (wr && adr == `OFS_IRQ_MASK) begin
            mask_nxt = wb_dat_w[`NUM_CH-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Read data and acknowledge
    // ------------------------------------------------------------------
    // Unmapped addresses still ack, reading zero, so no bus hang
    always_comb begin
        ack_nxt   = take;
        rdata_nxt = rdata_r;
        if (take) begin
            rdata_nxt = `WORD_ZERO;
            for (int c = 0; c < `NUM_CH; c++) begin
                if (is_ctrl(adr, c)) begin
                    rdata_nxt = ctrl_r[c];
                end
            end
            unique case (adr)
                `OFS_FLAG:     rdata_nxt = flag_word;
                `OFS_REMAP:    rdata_nxt[3:0] = remap_r;
                `OFS_SRC_EN:   rdata_nxt[`NUM_SRC-1:0] = src_en_r;
                `OFS_IRQ_STAT: rdata_nxt[`NUM_CH-1:0] = stat_r;
                `OFS_IRQ_MASK: rdata_nxt[`NUM_CH-1:0] = mask_r;
                default:       rdata_nxt = rdata_nxt;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupts and requests
    // ------------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < `NUM_CH; c++) begin
            en_vec[c]   = ctrl_r[c][`BIT_EN];
            cirq_nxt[c] =
                (ev.full[c] & ctrl_r[c][`BIT_FULL_IE]) |
                (ev.half[c] & ctrl_r[c][`BIT_HALF_IE]) |
                (ev.err[c]  & ctrl_r[c][`BIT_ERR_IE]);
        end
        // Read clears only what it reported: an event at the capture
        // edge stays pending, and a new event still wins
        stat_nxt = (rd_stat ? stat_r & ~rdata_r[`NUM_CH-1:0] : stat_r) |
                   evt_full_done | evt_half_done | evt_xfer_error;
        irq_nxt  = |(stat_nxt & mask_nxt);
        // Disabled channel ignores its line entirely
        req_nxt  = routed & en_vec;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Software-visible settings
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int c = 0; c < `NUM_CH; c++) begin
                ctrl_r[c] <= `WORD_ZERO;
            end
            remap_r  <= '0;
            src_en_r <= '0;
            mask_r   <= '0;
        end else begin
            for (int c = 0; c < `NUM_CH; c++) begin
                ctrl_r[c] <= ctrl_nxt[c];
            end
            remap_r  <= remap_nxt;
            src_en_r <= src_en_nxt;
            mask_r   <= mask_nxt;
        end
    end

    // Interrupt and request state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stat_r   <= '0;
            req_r    <= '0;
            cirq_r   <= '0;
            irq_r    <= 1'b0;
        end else begin
            stat_r   <= stat_nxt;
            req_r    <= req_nxt;
            cirq_r   <= cirq_nxt;
            irq_r    <= irq_nxt;
        end
    end

    // Bus answer state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_r    <= 1'b0;
            rdata_r  <= `WORD_ZERO;
        end else begin
            ack_r    <= ack_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_ack   = ack_r;
    assign wb_dat_r = rdata_r;
    assign chan_req = req_r;
    assign chan_irq = cirq_r;
    assign irq      = irq_r;

    always_comb begin
        for (int c = 0; c < `NUM_CH; c++) begin
            channel_enable[c] = ctrl_r[c][`BIT_EN];
        end
    end

endmodule : dma_channel_irq_request_mux
`default_nettype wire

// ===== test/dma_mux_props.sv
// Concurrent checks on the mapping block's top ports
`timescale 1ns/1ps
`default_nettype none
module dma_mux_props
    import dma_mux_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Bus handshake
    input  wire logic       wb_cyc,
    input  wire logic       wb_stb,
    input  wire logic       wb_we,
    input  wire logic       wb_ack,
    // Events and requests
    input  wire logic [6:0] evt_full_done,
    input  wire logic [6:0] evt_half_done,
    input  wire logic [6:0] evt_xfer_error,
    input  wire logic [15:0] src_req,
    // Channel outputs
    input  wire logic [6:0] channel_enable,
    input  wire logic [6:0] chan_req,
    input  wire logic [6:0] chan_irq,
    input  wire logic       irq
);
    logic [6:0] evt_any;
    assign evt_any = evt_full_done | evt_half_done | evt_xfer_error;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_ack_once;
        wb_ack |=> !wb_ack;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack held longer than one cycle");
    property p_ack_answer;
        wb_cyc && wb_stb && !wb_ack |=> wb_ack;
    endproperty
    a_ack_answer: assert property (p_ack_answer)
        else $error("access not acknowledged next cycle");
    property p_en_by_write;
        !$stable(channel_enable) |->
            $past(wb_ack && wb_we) || $past(wb_ack && wb_we, 2);
    endproperty
    a_en_by_write: assert property (p_en_by_write)
        else $error("channel enable moved without a write");
    property p_req_source;
        |chan_req |-> |$past(src_req);
    endproperty
    a_req_source: assert property (p_req_source)
        else $error("channel request without any source request");
    property p_req_gated;
        (chan_req & ~channel_enable & ~$past(channel_enable)) == 7'h00;
    endproperty
    a_req_gated: assert property (p_req_gated)
        else $error("request passed on a disabled channel");
    property p_irq_cause;
        |(chan_irq & ~$past(chan_irq)) |-> |$past(evt_any, 2)
            || |$past(evt_any) || $past(wb_ack) || $past(wb_ack, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("channel interrupt rose without cause");
    property p_irq_drop;
        |($past(chan_irq) & ~chan_irq) |->
            $past(wb_ack && wb_we) || $past(wb_ack && wb_we, 2);
    endproperty
    a_irq_drop: assert property (p_irq_drop)
        else $error("channel interrupt fell without a write");
    property p_sum_rise;
        $rose(irq) |-> |$past(evt_any) || $past(wb_ack) || $past(wb_ack, 2);
    endproperty
    a_sum_rise: assert property (p_sum_rise)
        else $error("summary interrupt rose without cause");
    property p_sum_fall;
        $fell(irq) |-> $past(wb_ack);
    endproperty
    a_sum_fall: assert property (p_sum_fall)
        else $error("summary interrupt fell without an access");
endmodule : dma_mux_props
bind dma_channel_irq_request_mux dma_mux_props u_dma_mux_props (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_ack(wb_ack), .evt_full_done(evt_full_done),
    .evt_half_done(evt_half_done), .evt_xfer_error(evt_xfer_error),
    .src_req(src_req), .channel_enable(channel_enable),
    .chan_req(chan_req), .chan_irq(chan_irq), .irq(irq)
);
`default_nettype wire

// ===== test/periph_req_model.sv
// Behavioural peripherals raising transfer request levels
`timescale 1ns/1ps
`default_nettype none
module periph_req_model (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Levels the bench wants raised
    input  wire logic [15:0] want,
    // Request lines to the block
    output logic      [15:0] src_req
);
    // Registered so requests never change near the sampling edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            src_req <= 16'h0000;
        end else begin
            src_req <= want;
        end
    end
endmodule : periph_req_model
`default_nettype wire

// ===== test/test_dma_channel_irq_request_mux.sv
// Self-checking bench for the channel interrupt and request mapping block
`timescale 1ns/1ps
`default_nettype none
`include "dma_mux_params.svh"
module test_dma_channel_irq_request_mux;
    import dma_mux_pkg::*;
    logic       clk_sys = 1'b0;
    logic       rst     = 1'b1;
    logic       wb_cyc  = 1'b0;
    logic       wb_stb  = 1'b0;
    logic       wb_we   = 1'b0;
    logic [7:0] wb_adr  = 8'h00;
    logic [3:0] wb_sel  = 4'h0;
    word_t      wb_dat_w = 32'h0000_0000;
    word_t      wb_dat_r, q;
    logic       wb_ack, irq;
    logic [6:0] evt [3] = '{7'h00, 7'h00, 7'h00};
    chan_vec_t  channel_enable, chan_req, chan_irq;
    src_vec_t   want = 16'h0000;
    src_vec_t   src_req;
    int         failures = 0;
    int         n_tests = 0;
    logic [7:0] radr [9] = '{8'h00, 8'h04, 8'h08, 8'hA0, 8'hA4, 8'hA8,
                             8'hAC, 8'h03, 8'hF0};

    always #12.5 clk_sys = ~clk_sys;

    periph_req_model u_periph_req_model (.clk_sys(clk_sys), .rst(rst),
        .want(want), .src_req(src_req));
    dma_channel_irq_request_mux #(.ADR_W(8)) u_dma_channel_irq_request_mux (
        .clk_sys(clk_sys), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .evt_full_done(evt[0]), .evt_half_done(evt[1]),
        .evt_xfer_error(evt[2]), .src_req(src_req),
        .channel_enable(channel_enable), .chan_req(chan_req),
        .chan_irq(chan_irq), .irq(irq));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done

    task automatic chk(input word_t seen, input word_t exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus(input logic we, input logic [7:0] a, input word_t d,
                       input logic [3:0] s = 4'hF);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= a;
        wb_sel   <= s;
        wb_dat_w <= d;
        // Waits for the answer; only the watchdog ends a hang
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack !== 1'b1);
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        chk(32'(n), 32'h2);
    endtask : bus

    task automatic rd(input logic [7:0] a, input word_t exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd

    task automatic pulse(input int k, input int c);
        @(posedge clk_sys);
        evt[k][c] <= 1'b1;
        @(posedge clk_sys);
        evt[k][c] <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : pulse

    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : settle

    function automatic logic [7:0] ctl(int c);
        return 8'(`OFS_CTRL0 + `CTRL_STRIDE * c);
    endfunction : ctl

    function automatic int chan_of(int s, logic [3:0] rm);
        int b;
        b = int'((`SRC_RMP_BIT >> 4 * s) & 64'hF);
        if (rm[b]) return int'((`SRC_ALT_CH >> 4 * s) & 64'hF);
        return int'((`SRC_DEF_CH >> 4 * s) & 64'hF);
    endfunction : chan_of

    // Keeps one enabled source per channel, as software must
    function automatic src_vec_t pick(src_vec_t r, logic [3:0] rm);
        chan_vec_t used;
        used = 7'h00;
        pick = 16'h0000;
        for (int s = 0; s < 16; s++) begin
            if (r[s] && !used[chan_of(s, rm)]) begin
                pick[s] = 1'b1;
                used[chan_of(s, rm)] = 1'b1;
            end
        end
    endfunction : pick

    function automatic chan_vec_t exp_req(src_vec_t r, src_vec_t en,
                                          logic [3:0] rm);
        exp_req = 7'h00;
        for (int s = 0; s < 16; s++)
            if (r[s] && en[s]) exp_req[chan_of(s, rm)] = 1'b1;
    endfunction : exp_req

    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        test_done();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        int c;
        word_t d, e;
        logic [3:0] rm;
        src_vec_t en;
        chan_vec_t ce;
        void'($urandom(97));
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (radr[i]) rd(radr[i], 32'h0);
        for (c = 0; c < 7; c++) begin
            d = $urandom;
            bus(1'b1, ctl(c), d);
            rd(ctl(c), d & `CTRL_WMASK);
            chk(channel_enable[c], d[0]);
            bus(1'b1, ctl(c), 32'hFFFF_FFFF, 4'h3);
            rd(ctl(c), d & `CTRL_WMASK);
            bus(1'b1, ctl(c), d & 32'hFFFF_FFFE);
            rd(ctl(c), d & `CTRL_WMASK & 32'hFFFF_FFFE);
            chk(channel_enable[c], 32'h0);
        end
        for (c = 0; c < 7; c++) begin
            for (int k = 0; k < 3; k++) begin
                e = (32'h1 | 32'h2 << k) << 4 * c;
                bus(1'b1, ctl(c), 32'h2 << k);
                pulse(k, c);
                rd(`OFS_FLAG, e);
                chk(chan_irq, 32'h1 << c);
                bus(1'b1, `OFS_CLEAR, ~e);
                rd(`OFS_FLAG, e);
                bus(1'b1, `OFS_CLEAR, e & ~(32'h1 << 4 * c));
                rd(`OFS_FLAG, 32'h0);
                chk(chan_irq, 32'h0);
                bus(1'b1, ctl(c), 32'h2 << (k + 1) % 3);
                pulse(k, c);
                chk(chan_irq, 32'h0);
                bus(1'b1, `OFS_CLEAR, 32'h1 << 4 * c);
                rd(`OFS_FLAG, 32'h0);
            end
        end
        rd(`OFS_IRQ_STAT, 32'h7F);
        rd(`OFS_IRQ_STAT, 32'h0);
        chk(irq, 32'h0);
        bus(1'b1, `OFS_IRQ_MASK, 32'h7F);
        c = $urandom_range(6);
        pulse(2, c);
        chk(irq, 32'h1);
        rd(`OFS_IRQ_STAT, 32'h1 << c);
        #1;
        chk(irq, 32'h0);
        bus(1'b1, `OFS_IRQ_MASK, 32'h0);
        pulse(0, c);
        chk(irq, 32'h0);
        rd(`OFS_IRQ_STAT, 32'h1 << c);
        bus(1'b1, `OFS_CLEAR, 32'h0FFF_FFFF);
        for (c = 0; c < 7; c++) bus(1'b1, ctl(c), 32'h1);
        for (int s = 0; s < 16; s++) begin
            for (int r = 0; r < 2; r++) begin
                rm = r ? 4'hF : 4'h0;
                bus(1'b1, `OFS_REMAP, {28'h0, rm});
                bus(1'b1, `OFS_SRC_EN, 32'h1 << s);
                want <= 16'h1 << s;
                settle();
                chk(chan_req, 32'h1 << chan_of(s, rm));
                bus(1'b1, `OFS_SRC_EN, 32'h0);
                settle();
                chk(chan_req, 32'h0);
                want <= 16'h0000;
            end
        end
        for (int i = 0; i < 40; i++) begin
            rm = 4'($urandom);
            en = pick(16'($urandom), rm);
            ce = 7'($urandom);
            bus(1'b1, `OFS_REMAP, {28'h0, rm});
            bus(1'b1, `OFS_SRC_EN, {16'h0, en});
            for (c = 0; c < 7; c++) bus(1'b1, ctl(c), {31'h0, ce[c]});
            want <= 16'($urandom);
            settle();
            chk(chan_req, exp_req(want, en, rm) & ce);
        end
        test_done();
    end
endmodule : test_dma_channel_irq_request_mux
`default_nettype wire
